// ===== verilog/fft_result_spi_framer.sv
// Result framer: builds range, doppler and peak frames from transform
// results and hands them word by word to the serial shifter.
// Assumes all control inputs come from logic on core_clk.
`timescale 1ns/1ns

module fft_result_spi_framer #(
  parameter int HALF_CYCLES = fft_framer_pkg::LINK_HALF_CYCLES
) (
  input wire logic core_clk,                    // Core clock, 100 MHz
  input wire logic arst_n,                      // Asynchronous reset, active low
  input wire logic ce,                          // Clock enable
  input wire logic [1:0] resultMode,            // Output mode select
  input wire logic interleave,                  // Both channels on lane zero
  input wire logic goFrame,                     // Start one frame, pulse
  input wire logic rangeFrameStart,             // Restart chirp count, pulse
  input wire logic [8:0] rangePoints,           // Range points per chirp
  input wire logic sampleValid,                 // Sample pair offered
  output logic sampleReady,                     // Sample pair taken
  input wire logic [31:0] sampleCh0,            // Channel one result, re:im
  input wire logic [31:0] sampleCh1,            // Channel two result, re:im
  input wire logic [1:0][3:0][6:0] peakIndex,   // Per peak: v0, d0, v1, d1
  input wire logic [1:0][1:0][31:0] peakMag,    // Per peak, per channel
  output logic busy,                            // Frame in progress
  output logic sclk,                            // Serial clock pin
  output logic selN,                            // Select pin, active low
  output logic mosi0,                           // Data lane zero pin
  output logic mosi1                            // Data lane one pin
);

  typedef enum logic [2:0] {S_IDLE, S_HEAD, S_DATA, S_TAIL, S_PEAK, S_DONE} seq_state_t;

  fft_link_if lnk ();

  seq_state_t state_r;
  logic dop_r;
  logic intl_r;
  logic half_r;
  logic have_r;
  logic sampleReady_r;
  logic busy_r;
  logic [10:0] idx_r;
  logic [10:0] lastIdx_r;
  logic [8:0] pts_r;
  logic [8:0] chirp_r;
  logic [15:0] dopCnt_r;
  logic [2:0] pkStep_r;
  logic [1:0][31:0] dat_r;
  logic [1:0][15:0] sum_r;
  logic [1:0][3:0][6:0] pkIdx_r;
  logic [1:0][1:0][31:0] pkMag_r;
  logic [31:0] slotW0;
  logic [31:0] slotW1;
  logic curCh;
  logic canLoad;
  logic slotDone;

  // ----------------------------------------------------------------
  // Word builders
  // ----------------------------------------------------------------
  // Lanes differ only in their code bits; same layout otherwise
  function automatic logic [31:0] headWord(input logic dop, input logic ch,
      input logic [8:0] chirp, input logic [8:0] pts, input logic [15:0] cnt);
    logic [31:0] w;
    w = 32'h0;
    w[fft_framer_pkg::HDR_MARK_LSB +: 8] = fft_framer_pkg::HDR_MARK;
    if (dop) begin
      w[fft_framer_pkg::HDR_LANE_LSB +: 2] = ch ? fft_framer_pkg::DOP_LANE1
                                                : fft_framer_pkg::DOP_LANE0;
      w[fft_framer_pkg::DOP_HDR_FIX_LSB +: 6] = fft_framer_pkg::DOP_HDR_FIX;
      w[fft_framer_pkg::DOP_CNT_LSB +: 16] = cnt;
    end else begin
      w[fft_framer_pkg::HDR_LANE_LSB +: 2] = ch ? fft_framer_pkg::RNG_LANE1
                                                : fft_framer_pkg::RNG_LANE0;
      w[fft_framer_pkg::RNG_HDR_FIX_LSB +: 2] = fft_framer_pkg::RNG_HDR_FIX;
      w[fft_framer_pkg::HDR_CHIRP_LSB +: 9] = chirp;
      w[fft_framer_pkg::HDR_PTS_LSB +: 9] = 9'(pts + 9'h1);
    end
    return w;
  endfunction : headWord

  function automatic logic [31:0] tailWord(input logic dop, input logic ch,
      input logic [15:0] sum, input logic [8:0] chirp);
    logic [31:0] w;
    w = 32'h0;
    w[fft_framer_pkg::TAIL_SUM_LSB +: 16] = sum;
    if (dop) begin
      w[15:0] = fft_framer_pkg::DOP_TAIL_PAT;
    end else begin
      w[fft_framer_pkg::TAIL_LANE_LSB +: 2] = ch ? fft_framer_pkg::RNG_LANE1
                                                 : fft_framer_pkg::RNG_LANE0;
      w[fft_framer_pkg::RNG_TAIL_FIX_LSB +: 2] = fft_framer_pkg::RNG_TAIL_FIX;
      w[fft_framer_pkg::TAIL_CHIRP_LSB +: 4] = chirp[3:0];
      w[7:0] = fft_framer_pkg::RNG_TAIL_PAT;
    end
    return w;
  endfunction : tailWord

  // Index word, then channel one and channel two magnitudes, per peak
  function automatic logic [31:0] peakWord(input logic [2:0] step,
      input logic [1:0][3:0][6:0] ix, input logic [1:0][1:0][31:0] mg);
    logic [31:0] w;
    logic pk;
    pk = (step >= 3'h3);
    case (step)
      3'h0, 3'h3: w = {1'b0, ix[pk][0], 1'b0, ix[pk][1],
                       1'b0, ix[pk][2], 1'b0, ix[pk][3]};
      3'h1, 3'h4: w = mg[pk][0];
      3'h2, 3'h5: w = mg[pk][1];
      default: w = 32'h0;
    endcase
    return w;
  endfunction : peakWord

  // ----------------------------------------------------------------
  // Slot word selection
  // ----------------------------------------------------------------
  assign curCh = intl_r & half_r;                       // Channel one first
  assign canLoad = lnk.ready && !lnk.load;              // Shifter sees offer one cycle late
  assign slotDone = !intl_r || half_r;

  always_comb begin
    slotW0 = 32'h0;
    slotW1 = 32'h0;
    case (state_r)
      S_HEAD: begin
        slotW0 = headWord(dop_r, curCh, chirp_r, pts_r, dopCnt_r);
        slotW1 = headWord(dop_r, 1'b1, chirp_r, pts_r, dopCnt_r);
      end
      S_DATA: begin
        slotW0 = dat_r[curCh];
        slotW1 = dat_r[1];
      end
      S_TAIL: begin
        slotW0 = tailWord(dop_r, curCh, sum_r[curCh], chirp_r);
        slotW1 = tailWord(dop_r, 1'b1, sum_r[1], chirp_r);
      end
      S_PEAK: slotW0 = peakWord(pkStep_r, pkIdx_r, pkMag_r);
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Header, data and tail slots; an interleaved slot takes two offers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= S_IDLE;
      dop_r <= 1'b0;
      intl_r <= 1'b0;
      half_r <= 1'b0;
      have_r <= 1'b0;
      sampleReady_r <= 1'b0;
      busy_r <= 1'b0;
      idx_r <= 11'h0;
      lastIdx_r <= 11'h0;
      pts_r <= 9'h0;
      pkStep_r <= 3'h0;
      pkIdx_r <= '0;
      pkMag_r <= '0;
      dat_r <= '0;
      lnk.load <= 1'b0;
      lnk.word0 <= 32'h0;
      lnk.word1 <= 32'h0;
      lnk.lane1En <= 1'b0;
      lnk.frameActive <= 1'b0;
    end else if (ce) begin
      lnk.load <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (goFrame && resultMode != 2'(fft_framer_pkg::MODE_OFF)) begin
            dop_r <= (resultMode == 2'(fft_framer_pkg::MODE_DOPPLER));
            intl_r <= interleave;
            pts_r <= rangePoints;
            lastIdx_r <= (resultMode == 2'(fft_framer_pkg::MODE_DOPPLER))
                       ? 11'(fft_framer_pkg::DOP_POINTS - 1)
                       : 11'({2'h0, rangePoints} - 11'h1);
            pkIdx_r <= peakIndex;
            pkMag_r <= peakMag;
            idx_r <= 11'h0;
            half_r <= 1'b0;
            have_r <= 1'b0;
            pkStep_r <= 3'h0;
            busy_r <= 1'b1;
            lnk.frameActive <= 1'b1;
            state_r <= (resultMode == 2'(fft_framer_pkg::MODE_PEAK)) ? S_PEAK : S_HEAD;
          end
        end
        S_HEAD, S_TAIL: begin
          if (canLoad) begin
            lnk.load <= 1'b1;
            lnk.word0 <= slotW0;
            lnk.word1 <= slotW1;
            lnk.lane1En <= !intl_r;
            half_r <= !slotDone;
            if (slotDone && state_r == S_TAIL) begin
              state_r <= S_DONE;
            end else if (slotDone && !dop_r && pts_r == 9'h0) begin
              state_r <= S_TAIL;                                        // No range points
            end else if (slotDone) begin
              state_r <= S_DATA;
              sampleReady_r <= 1'b1;
            end
          end
        end
        S_DATA: begin
          if (!have_r) begin
            if (sampleValid && sampleReady_r) begin
              dat_r[0] <= sampleCh0;
              dat_r[1] <= sampleCh1;
              sampleReady_r <= 1'b0;
              have_r <= 1'b1;
            end
          end else if (canLoad) begin
            lnk.load <= 1'b1;
            lnk.word0 <= slotW0;
            lnk.word1 <= slotW1;
            lnk.lane1En <= !intl_r;
            half_r <= !slotDone;
            if (slotDone) begin
              have_r <= 1'b0;
              if (idx_r == lastIdx_r) begin
                state_r <= S_TAIL;
              end else begin
                idx_r <= idx_r + 11'h1;
                sampleReady_r <= 1'b1;
              end
            end
          end
        end
        S_PEAK: begin
          if (canLoad) begin
            lnk.load <= 1'b1;
            lnk.word0 <= slotW0;
            lnk.word1 <= 32'h0;
            lnk.lane1En <= 1'b0;
            pkStep_r <= pkStep_r + 3'h1;
            if (pkStep_r == 3'(fft_framer_pkg::PEAK_WORDS - 1)) state_r <= S_DONE;
          end
        end
        S_DONE: begin
          // Hold select until the last word has left the shifter
          if (canLoad) begin
            lnk.frameActive <= 1'b0;
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Data words are not stored beyond the current pair
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_r <= '0;
    end else if (ce) begin
      if (state_r == S_IDLE) begin
        sum_r <= '0;
      end else if (state_r == S_DATA && !have_r && sampleValid && sampleReady_r) begin
        sum_r[0] <= 16'(sum_r[0] + sampleCh0[31:16] + sampleCh0[15:0]);
        sum_r[1] <= 16'(sum_r[1] + sampleCh1[31:16] + sampleCh1[15:0]);
      end
    end
  end

  // Frame numbering: chirp restart wins over a finishing chirp
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chirp_r <= 9'h0;
      dopCnt_r <= 16'h0;
    end else if (ce) begin
      if (rangeFrameStart) begin
        chirp_r <= 9'h0;
      end else if (state_r == S_DONE && canLoad && !dop_r && pkStep_r == 3'h0) begin
        chirp_r <= chirp_r + 9'h1;
      end
      if (state_r == S_DONE && canLoad && dop_r) begin
        dopCnt_r <= dopCnt_r + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shifter and pins
  // ----------------------------------------------------------------
  fft_word_shifter #(.HALF_CYCLES(HALF_CYCLES)) u_shifter (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .lnk(lnk)
  );

  assign sampleReady = sampleReady_r;
  assign busy = busy_r;
  assign sclk = lnk.sclk;
  assign selN = lnk.selN;
  assign mosi0 = lnk.mosi0;
  assign mosi1 = lnk.mosi1;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_startDop;
    ce && state_r == S_IDLE && goFrame && resultMode == 2'(fft_framer_pkg::MODE_DOPPLER);
  endsequence

  property p_dopOnlyInMode;
    (state_r == S_HEAD && $past(state_r) == S_IDLE && dop_r)
      |-> $past(resultMode) == 2'(fft_framer_pkg::MODE_DOPPLER);
  endproperty
  a_dopOnlyInMode: assert property (p_dopOnlyInMode) else $error("doppler outside mode");

  property p_dopStart;
    s_startDop |=> state_r == S_HEAD && dop_r && busy ##1 !selN;
  endproperty
  a_dopStart: assert property (p_dopStart) else $error("doppler frame did not start");

  property p_dataWord;
    (ce && state_r == S_DATA && have_r && canLoad && !intl_r)
      |=> lnk.load && lnk.word0 == $past(dat_r[0]) && lnk.word1 == $past(dat_r[1]);
  endproperty
  a_dataWord: assert property (p_dataWord) else $error("data word mismatch");

  property p_headLane;
    (ce && state_r == S_HEAD && canLoad && !intl_r)
      |=> lnk.word0[23:22] == {dop_r, 1'b0} && lnk.word1[23:22] == {dop_r, 1'b1};
  endproperty
  a_headLane: assert property (p_headLane) else $error("header lane code wrong");

  property p_frameCount;
    $changed(dopCnt_r) |-> dopCnt_r == 16'($past(dopCnt_r) + 16'h1) && $past(dop_r);
  endproperty
  a_frameCount: assert property (p_frameCount) else $error("frame counter step wrong");

  property p_dopLength;
    (state_r == S_DATA && dop_r) |-> idx_r <= 11'(fft_framer_pkg::DOP_POINTS - 1);
  endproperty
  a_dopLength: assert property (p_dopLength) else $error("too many doppler words");

  property p_dopTail;
    (ce && state_r == S_TAIL && canLoad && dop_r)
      |=> lnk.word0[15:0] == fft_framer_pkg::DOP_TAIL_PAT
          && lnk.word0[31:16] == $past(sum_r[curCh]);
  endproperty
  a_dopTail: assert property (p_dopTail) else $error("doppler tail wrong");

  property p_interleaveLane;
    (lnk.load && (intl_r || state_r == S_PEAK || $past(state_r) == S_PEAK)) |-> !lnk.lane1En;
  endproperty
  a_interleaveLane: assert property (p_interleaveLane) else $error("lane one used");

  property p_peakIndex;
    (ce && state_r == S_PEAK && canLoad && (pkStep_r == 3'h0 || pkStep_r == 3'h3))
      |=> !lnk.word0[31] && !lnk.word0[23] && !lnk.word0[15] && !lnk.word0[7];
  endproperty
  a_peakIndex: assert property (p_peakIndex) else $error("peak index pad bit set");

  property p_rangeTail;
    (ce && state_r == S_TAIL && canLoad && !dop_r)
      |=> lnk.word0[11:8] == $past(chirp_r[3:0]) && lnk.word0[15:14] == {1'b0, $past(curCh)};
  endproperty
  a_rangeTail: assert property (p_rangeTail) else $error("range tail fields wrong");

endmodule : fft_result_spi_framer

// ===== verilog/fft_framer_pkg.sv
// Constants shared by the result framer and its word shifter.
// Assumes a single core clock; nothing here depends on the link rate.
package fft_framer_pkg;

  // ----------------------------------------------------------------
  // Link sizing and timing
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 32;
  localparam int LINK_HALF_CYCLES = 4;    // 40 ns half period at 100 MHz
  localparam int DOP_POINTS = 1024;       // Data words per doppler frame
  localparam int PEAK_WORDS = 6;          // Index, two magnitudes, twice

  // ----------------------------------------------------------------
  // Header layout
  // ----------------------------------------------------------------
  localparam int HDR_MARK_LSB = 24;
  localparam logic [7:0] HDR_MARK = 8'haa;
  localparam int HDR_LANE_LSB = 22;
  localparam int RNG_HDR_FIX_LSB = 20;
  localparam logic [1:0] RNG_HDR_FIX = 2'h3;
  localparam int HDR_CHIRP_LSB = 11;
  localparam int HDR_PTS_LSB = 0;
  localparam int DOP_HDR_FIX_LSB = 16;
  localparam logic [5:0] DOP_HDR_FIX = 6'h3f;
  localparam int DOP_CNT_LSB = 0;
  localparam logic [1:0] RNG_LANE0 = 2'h0;
  localparam logic [1:0] RNG_LANE1 = 2'h1;
  localparam logic [1:0] DOP_LANE0 = 2'h2;
  localparam logic [1:0] DOP_LANE1 = 2'h3;

  // ----------------------------------------------------------------
  // Tail layout
  // ----------------------------------------------------------------
  localparam int TAIL_SUM_LSB = 16;
  localparam int TAIL_LANE_LSB = 14;
  localparam int RNG_TAIL_FIX_LSB = 12;
  localparam logic [1:0] RNG_TAIL_FIX = 2'h3;
  localparam int TAIL_CHIRP_LSB = 8;
  localparam logic [7:0] RNG_TAIL_PAT = 8'h55;
  localparam logic [15:0] DOP_TAIL_PAT = 16'h5555;

  typedef enum logic [1:0] {MODE_OFF, MODE_RANGE, MODE_DOPPLER, MODE_PEAK} result_mode_t;

endpackage : fft_framer_pkg

// ===== verilog/fft_link_if.sv
// Word hand-off between the frame sequencer and the serial shifter.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
interface fft_link_if;
  logic [31:0] word0;     // Word for data lane zero
  logic [31:0] word1;     // Word for data lane one
  logic lane1En;          // Lane one carries word1
  logic load;             // One-cycle word offer
  logic ready;            // Shifter idle, may take a word
  logic frameActive;      // Select should be asserted
  logic sclk;             // Serial clock pin level
  logic selN;             // Select pin level, active low
  logic mosi0;            // Data lane zero pin level
  logic mosi1;            // Data lane one pin level
  modport seq (output word0, word1, lane1En, load, frameActive,
               input ready, sclk, selN, mosi0, mosi1);
  modport ser (input word0, word1, lane1En, load, frameActive,
               output ready, sclk, selN, mosi0, mosi1);
endinterface : fft_link_if

// ===== verilog/fft_word_shifter.sv
// Serial shifter: sends one 32-bit word per offer, MSB first, on two lanes.
// Assumes offers come only while ready is high; the clock idles low.
`timescale 1ns/1ns
module fft_word_shifter #(
  parameter int HALF_CYCLES = fft_framer_pkg::LINK_HALF_CYCLES
) (
  input wire logic core_clk,   // Core clock
  input wire logic arst_n,     // Asynchronous reset, active low
  input wire logic ce,         // Clock enable, freezes all state
  fft_link_if.ser lnk          // Words in, pins out
);

  logic busy_r;
  logic [4:0] bitCnt_r;
  logic [7:0] divCnt_r;
  logic [31:0] sh0_r;
  logic [31:0] sh1_r;
  logic [5:0] edges_r;

  assign lnk.ready = !busy_r;

  // ----------------------------------------------------------------
  // Shift engine: data changes on the falling edge, host samples rising
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      bitCnt_r <= 5'h0;
      divCnt_r <= 8'h0;
      sh0_r <= 32'h0;
      sh1_r <= 32'h0;
      lnk.sclk <= 1'b0;
      lnk.mosi0 <= 1'b0;
      lnk.mosi1 <= 1'b0;
    end else if (ce) begin
      if (!busy_r) begin
        lnk.sclk <= 1'b0;
        divCnt_r <= 8'h0;
        if (lnk.load) begin
          busy_r <= 1'b1;
          bitCnt_r <= 5'h0;
          sh0_r <= lnk.word0;
          sh1_r <= lnk.lane1En ? lnk.word1 : 32'h0;   // Idle lane stays low
          lnk.mosi0 <= lnk.word0[31];                   // MSB leads
          lnk.mosi1 <= lnk.lane1En & lnk.word1[31];
        end
      end else if (divCnt_r == 8'(HALF_CYCLES - 1)) begin
        divCnt_r <= 8'h0;
        lnk.sclk <= !lnk.sclk;
        if (lnk.sclk) begin
          if (bitCnt_r == 5'h1f) begin
            busy_r <= 1'b0;                             // 32 bits per word
          end else begin
            bitCnt_r <= bitCnt_r + 5'h1;
            sh0_r <= {sh0_r[30:0], 1'b0};
            sh1_r <= {sh1_r[30:0], 1'b0};
            lnk.mosi0 <= sh0_r[30];
            lnk.mosi1 <= sh1_r[30];
          end
        end
      end else begin
        divCnt_r <= divCnt_r + 8'h1;
      end
    end
  end

  // Select follows the sequencer with one register stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.selN <= 1'b1;
    end else if (ce) begin
      lnk.selN <= !lnk.frameActive;
    end
  end

  // Falling edges seen per word, only for checking
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      edges_r <= 6'h0;
    end else if (ce) begin
      if (!busy_r) edges_r <= 6'h0;
      else if (divCnt_r == 8'(HALF_CYCLES - 1) && lnk.sclk) edges_r <= edges_r + 6'h1;
    end
  end

  property p_wordLength;
    @(posedge core_clk) disable iff (!arst_n)
    $fell(busy_r) |-> edges_r == 6'h20;
  endproperty
  a_wordLength: assert property (p_wordLength) else $error("word not 32 bits");

  property p_msbFirst;
    @(posedge core_clk) disable iff (!arst_n)
    (ce && lnk.load && !busy_r) |=> lnk.mosi0 == $past(lnk.word0[31]) && busy_r;
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("first bit is not MSB");

endmodule : fft_word_shifter

// ===== verification/host_model.sv
// Host model: gathers 32-bit words from both data lanes of the result link.
// Assumes the device drives sclk (idle low) and holds selN low for a frame.
`timescale 1ns/1ns
module host_model (
  input wire logic sclk,   // Serial clock from the device
  input wire logic selN,   // Select, active low
  input wire logic mosi0,  // Data lane zero
  input wire logic mosi1,  // Data lane one
  output logic [31:0] rx0, // Last word of lane zero
  output logic [31:0] rx1, // Last word of lane one
  output logic rxTick      // Toggles once per word
);
  // ----
  // Word capture
  // ----
  logic [31:0] sh0, sh1;
  int nBits;
  // Select high drops a partial word, so a short frame never leaks into the next
  always @(posedge sclk or posedge selN) begin
    if (selN) begin
      nBits = 0;
    end else begin
      sh0 = {sh0[30:0], mosi0};
      sh1 = {sh1[30:0], mosi1};
      nBits++;
      if (nBits == 32) begin
        rx0 = sh0;
        rx1 = sh1;
        nBits = 0;
        rxTick = ~rxTick;
      end
    end
  end
  initial rxTick = 1'b0;
endmodule : host_model

// ===== verification/tb.sv
// Testbench for the result framer: range, doppler and peak frames.
// Assumes host_model beside it; sclk runs fast so a doppler frame fits.
`timescale 1ns/1ns
module tb;
  // ----
  // Stimulus and expectations
  // ----
  typedef struct packed {logic [1:0] mode; logic il; logic [8:0] pts;} row_t;
  logic core_clk, arst_n, goFrame, rangeFrameStart, sampleValid, interleave;
  logic [1:0] resultMode;
  logic [8:0] rangePoints;
  logic [1:0][3:0][6:0] peakIndex;
  logic [1:0][1:0][31:0] peakMag;
  logic sampleReady, busy, sclk, selN, mosi0, mosi1, rxTick;
  logic [31:0] rx0, rx1;
  logic [15:0] k, chirp, dcnt;
  logic [31:0] q0[$], q1[$], e0[$], e1[$];
  int n_errors, cmp_count;
  row_t rows[5] = '{'{2'h1, 1'b0, 9'h3}, '{2'h1, 1'b0, 9'h0}, '{2'h1, 1'b1, 9'h2},
                    '{2'h3, 1'b0, 9'h0}, '{2'h0, 1'b0, 9'h3}};
  function automatic logic [31:0] smp(input int c, input int i);
    logic [15:0] j;
    j = 16'(i);
    return c ? {j + 16'h7000, ~j} : {j + 16'h1234, j};
  endfunction : smp
  wire [31:0] s0 = smp(0, k);
  wire [31:0] s1 = smp(1, k);
  fft_result_spi_framer #(.HALF_CYCLES(1)) fft_result_spi_framer_i (.core_clk(core_clk),
    .arst_n(arst_n), .ce(1'b1), .resultMode(resultMode), .interleave(interleave),
    .goFrame(goFrame), .rangeFrameStart(rangeFrameStart), .rangePoints(rangePoints),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleCh0(s0), .sampleCh1(s1),
    .peakIndex(peakIndex), .peakMag(peakMag), .busy(busy), .sclk(sclk), .selN(selN),
    .mosi0(mosi0), .mosi1(mosi1));
  host_model host_model_i (.sclk(sclk), .selN(selN), .mosi0(mosi0), .mosi1(mosi1),
    .rx0(rx0), .rx1(rx1), .rxTick(rxTick));
  // Collect words and step the sample index on every take
  always @(rxTick) begin
    q0.push_back(rx0);
    q1.push_back(rx1);
  end
  always @(posedge core_clk) if (sampleValid && sampleReady) k <= k + 16'h1;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] csum(input int c, input int n);
    logic [15:0] s;
    logic [31:0] d;
    s = '0;
    for (int i = 0; i < n; i++) begin
      d = smp(c, i);
      s += d[31:16] + d[15:0];
    end
    return s;
  endfunction : csum
  // Expected words per lane; lane one stays low when not in use
  task automatic build(input row_t r);
    logic [1:0] ln;
    logic [31:0] w[2][$];
    int n;
    e0 = {};
    e1 = {};
    n = r.mode[1] ? 1024 : int'(r.pts);
    if (r.mode == 2'h3) begin
      for (int p = 0; p < 2; p++) begin
        e0.push_back({1'b0, peakIndex[p][0], 1'b0, peakIndex[p][1], 1'b0, peakIndex[p][2],
                      1'b0, peakIndex[p][3]});
        e0.push_back(peakMag[p][0]);
        e0.push_back(peakMag[p][1]);
      end
    end else if (r.mode != 2'h0) begin
      for (int c = 0; c < 2; c++) begin
        ln = {r.mode[1], 1'(c)};
        w[c].push_back(r.mode[1] ? {8'haa, ln, 6'h3f, dcnt}
                                 : {8'haa, ln, 2'h3, chirp[8:0], 2'h0, r.pts + 9'h1});
        for (int i = 0; i < n; i++) w[c].push_back(smp(c, i));
        w[c].push_back(r.mode[1] ? {csum(c, n), 16'h5555}
                                 : {csum(c, n), ln, 2'h3, chirp[3:0], 8'h55});
      end
      foreach (w[0][i]) begin
        e0.push_back(w[0][i]);
        if (r.il) e0.push_back(w[1][i]);
        else e1.push_back(w[1][i]);
      end
    end
    while (e1.size() < e0.size()) e1.push_back('0);
  endtask : build
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h got %h", nm, ex, got);
    end
  endtask : cmp
  // One frame: start it, wait out busy under a bound, compare both lanes
  task automatic run(input row_t r);
    int t;
    build(r);
    q0 = {};
    q1 = {};
    @(posedge core_clk);
    {resultMode, interleave, rangePoints} <= r;
    k <= '0;
    goFrame <= 1'b1;
    @(posedge core_clk);
    goFrame <= 1'b0;
    #1;
    for (t = 0; busy === 1'b1 && t < 80000; t++) @(posedge core_clk);
    if (t == 80000) n_errors++;
    repeat (4) @(posedge core_clk);
    cmp("count0", 32'(e0.size()), 32'(q0.size()));
    for (int i = 0; i < e0.size() && i < q0.size(); i++)
      cmp("lane0", e0[i], q0[i]);
    for (int i = 0; i < e1.size() && i < q1.size(); i++)
      cmp("lane1", e1[i], q1[i]);
    if (r.mode == 2'h1) chirp++;
    if (r.mode == 2'h2) dcnt++;
    $display("test done mode %0d interleave %0d points %0d", r.mode, r.il, r.pts);
  endtask : run
  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    {arst_n, goFrame, rangeFrameStart, sampleValid, resultMode, interleave, rangePoints} = '0;
    peakIndex = {4{7'h7f, 7'h2a}};
    peakMag = {32'h89abcdef, 32'h01234567, 32'hfedcba98, 32'h76543210};
    {k, chirp, dcnt, n_errors, cmp_count} = '0;
    repeat (5) @(posedge core_clk);
    cmp("reset", 32'h1, {28'h0, busy, sampleReady, sclk, selN});
    $display("test done reset");
    arst_n <= 1'b1;
    sampleValid <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    @(posedge core_clk);
    rangeFrameStart <= 1'b1;
    chirp = '0;
    @(posedge core_clk);
    rangeFrameStart <= 1'b0;
    run(rows[0]);
    run(row_t'{2'h2, 1'b0, 9'h0});
    end_sim();
  end
  // Watchdog: well past the longest expected run, beyond the 80000-cycle bound of one run
  initial begin
    #900000;
    n_errors++;
    end_sim();
  end
endmodule : tb
